// [hdl/pic_arbiter.sv]
// winner search over pending user sources
`timescale 1ns/100ps
module pic_arbiter #(
  parameter int N = pic_pkg::N_SRC
) (
  input wire logic [N-1:0] pend,
  input wire logic [3*N-1:0] prio,
  output logic found,
  output logic [6:0] idx,
  output logic [2:0] level
);
  import pic_pkg::*;
  if (N < 1 || N > 120) begin : g_bad_n
    $error("pic_arbiter: source count out of range");
  end
  always_comb begin
    found = 1'b0;
    idx = 7'h00;
    level = 3'h0;
    // walk downward so the lowest index wins equal levels
    for (int i = N - 1; i >= 0; i--) begin
      if (pend[i] && prio[3*i +: 3] >= level) begin
        found = 1'b1;
        idx = 7'(i);
        level = prio[3*i +: 3];
      end
    end
  end
endmodule : pic_arbiter

// [hdl/pic_controller.sv]
// interrupt controller core with AXI4-Lite register slave
`timescale 1ns/100ps
module pic_controller #(
  parameter int NSRC = pic_pkg::N_SRC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [pic_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [pic_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [pic_pkg::N_FLAGS-1:0] periph_req,
  input wire logic [pic_pkg::N_EXT-1:0] ext_irq_pin,
  input wire logic [pic_pkg::N_TRAP-1:0] trap_req,
  input wire logic cpu_priority_top,
  output logic irq_req,
  output pic_pkg::pic_vec_t irq_sel,
  output logic alt_table_sel
);
  import pic_pkg::*;

  if (NSRC < 1 || NSRC > N_SRC) begin : g_bad_nsrc
    $error("pic_controller: NSRC exceeds priority fields");
  end

  // register state
  logic nest_dis_q;
  logic [N_TRAP-1:0] trap_flag_q;
  logic [15:0] ctrl_b_q;
  logic [15:0] flag_q [N_FLAG_WORDS];
  logic [15:0] en_q [N_FLAG_WORDS];
  logic [15:0] prio_q [N_PRIO_WORDS];
  logic [2:0] cpu_low_q;
  pic_vec_t vstat_q;
  logic irq_req_q;

  // bus state
  logic aw_have_q, w_have_q;
  logic [5:0] aw_idx_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [15:0] rdata_q;

  // external pin synchronisers
  logic [N_EXT-1:0] ext_s1_q, ext_s2_q, ext_s3_q;

  // ---------------- AXI4-Lite slave ----------------
  assign awready = ~aw_have_q & ~bvalid_q;
  assign wready = ~w_have_q & ~bvalid_q;
  assign arready = ~rvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = {16'h0000, rdata_q};

  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire ar_take = arvalid & arready;
  wire do_write = aw_have_q & w_have_q & ~bvalid_q;

  function automatic logic mapped(input logic [5:0] i);
    mapped = i <= IDX_CORE;
  endfunction : mapped

  wire wr_ok = do_write & mapped(aw_idx_q);
  wire [5:0] ar_idx = araddr[7:2];

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] d,
                                        input logic [1:0] s,
                                        input logic [15:0] m);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    merge = r & m;
  endfunction : merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 6'h00;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= awaddr[7:2];
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= wdata[15:0];
        wstrb_q <= wstrb[1:0];
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ---------------- read path ----------------
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (ar_idx == IDX_CTRL_A) begin
      rd_word[NEST_DIS_BIT] = nest_dis_q;
      rd_word[N_TRAP-1:0] = trap_flag_q;
    end else if (ar_idx == IDX_CTRL_B) begin
      rd_word = ctrl_b_q;
    end else if (ar_idx >= IDX_FLAG0 && ar_idx < IDX_EN0) begin
      rd_word = flag_q[3'(ar_idx - IDX_FLAG0)];
    end else if (ar_idx >= IDX_EN0 && ar_idx < IDX_PRIO0) begin
      rd_word = en_q[3'(ar_idx - IDX_EN0)];
    end else if (ar_idx >= IDX_PRIO0 && ar_idx < IDX_VSTAT) begin
      rd_word = prio_q[5'(ar_idx - IDX_PRIO0)];
    end else if (ar_idx == IDX_VSTAT) begin
      rd_word[6:0] = vstat_q.vector;
      rd_word[VS_LEVEL_LSB +: 4] = vstat_q.level;
    end else if (ar_idx == IDX_CPU_SR) begin
      rd_word[CPU_LOW_LSB +: 3] = cpu_low_q;
    end else if (ar_idx == IDX_CORE) begin
      rd_word[CPU_TOP_BIT] = cpu_priority_top;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 16'h0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_word;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- external pins ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
    end else begin
      ext_s1_q <= ext_irq_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // polarity bit 1 selects the falling edge, 0 the rising edge
  wire [N_EXT-1:0] ext_pol = ctrl_b_q[N_EXT-1:0];
  wire [N_EXT-1:0] ext_evt = (ext_pol & ext_s3_q & ~ext_s2_q)
                           | (~ext_pol & ext_s2_q & ~ext_s3_q);

  logic [N_FLAGS-1:0] flag_set;
  always_comb begin
    flag_set = periph_req;
    for (int k = 0; k < N_EXT; k++) begin
      flag_set[EXT_SRC[k]] = flag_set[EXT_SRC[k]] | ext_evt[k];
    end
  end

  // ---------------- control and flag registers ----------------
  wire wr_ctrl_a = wr_ok & (aw_idx_q == IDX_CTRL_A);
  wire [15:0] ctrl_a_new = merge({nest_dis_q, 10'h000, trap_flag_q},
                                 wdata_q, wstrb_q, FULL_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nest_dis_q <= 1'b0;
      trap_flag_q <= '0;
      ctrl_b_q <= 16'h0000;
      cpu_low_q <= 3'h0;
    end else begin
      if (wr_ctrl_a) begin
        nest_dis_q <= ctrl_a_new[NEST_DIS_BIT];
      end
      // a trap arriving with a clearing write still lands
      trap_flag_q <= (wr_ctrl_a ? ctrl_a_new[N_TRAP-1:0] : trap_flag_q)
                   | trap_req;
      if (wr_ok && aw_idx_q == IDX_CTRL_B) begin
        ctrl_b_q <= merge(ctrl_b_q, wdata_q, wstrb_q, FULL_MASK);
      end
      if (wr_ok && aw_idx_q == IDX_CPU_SR && wstrb_q[0]) begin
        cpu_low_q <= wdata_q[CPU_LOW_LSB +: 3];
      end
    end
  end

  assign alt_table_sel = ctrl_b_q[ALT_TABLE_BIT];

  for (genvar w = 0; w < N_FLAG_WORDS; w++) begin : g_flag
    localparam logic [15:0] MASK = (w == 2) ? EN2_MASK : FULL_MASK;
    wire wr_f = wr_ok & (aw_idx_q == IDX_FLAG0 + 6'(w));
    wire wr_e = wr_ok & (aw_idx_q == IDX_EN0 + 6'(w));
    wire [15:0] kept = wr_f ? merge(flag_q[w], wdata_q, wstrb_q, MASK)
                            : flag_q[w];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_q[w] <= 16'h0000;
        en_q[w] <= EN_RESET;
      end else begin
        flag_q[w] <= (kept | flag_set[16*w +: 16]) & MASK;
        if (wr_e) begin
          en_q[w] <= merge(en_q[w], wdata_q, wstrb_q, MASK);
        end
      end
    end
  end

  for (genvar p = 0; p < N_PRIO_WORDS; p++) begin : g_prio
    wire wr_p = wr_ok & (aw_idx_q == IDX_PRIO0 + 6'(p));
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prio_q[p] <= PRIO_RESET;
      end else if (wr_p) begin
        prio_q[p] <= merge(prio_q[p], wdata_q, wstrb_q, PRIO_MASK);
      end
    end
  end

  // ---------------- selection ----------------
  // flat views in natural order: source i uses flag bit i, enable
  // bit i and priority bits 3i+2:3i
  logic [N_FLAGS-1:0] flag_flat, en_flat;
  logic [3*N_SRC-1:0] prio_flat;
  always_comb begin
    for (int w = 0; w < N_FLAG_WORDS; w++) begin
      flag_flat[16*w +: 16] = flag_q[w];
      en_flat[16*w +: 16] = en_q[w];
    end
    for (int p = 0; p < N_PRIO_WORDS; p++) begin
      for (int f = 0; f < 4; f++) begin
        prio_flat[12*p + 3*f +: 3] = prio_q[p][4*f +: 3];
      end
    end
  end

  wire [3:0] cpu_level = {cpu_priority_top, cpu_low_q};
  // nesting disabled: no user source preempts a running handler
  wire [3:0] user_floor = (nest_dis_q && cpu_level != 4'h0)
                          ? {1'b0, LEVEL_USER_MAX} : cpu_level;

  logic [NSRC-1:0] user_pend;
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      // zero priority never beats any floor; level 7 floor blocks all
      user_pend[i] = flag_flat[i] & en_flat[i]
                   & ({1'b0, prio_flat[3*i +: 3]} > user_floor);
    end
  end

  logic user_found;
  logic [6:0] user_idx;
  logic [2:0] user_lvl;
  pic_arbiter #(.N(NSRC)) u_arb (
    .pend(user_pend),
    .prio(prio_flat[3*NSRC-1:0]),
    .found(user_found),
    .idx(user_idx),
    .level(user_lvl)
  );

  // traps: lower index holds the higher fixed level, 14 down to 10
  logic trap_found;
  pic_vec_t trap_win;
  always_comb begin
    trap_found = 1'b0;
    trap_win = '0;
    for (int k = N_TRAP - 1; k >= 0; k--) begin
      if (trap_flag_q[k] && (TRAP_LEVEL_TOP - 4'(k)) > cpu_level) begin
        trap_found = 1'b1;
        trap_win.level = TRAP_LEVEL_TOP - 4'(k);
        trap_win.vector = 7'(k + 1);
      end
    end
  end

  pic_vec_t user_win;
  assign user_win.level = {1'b0, user_lvl};
  assign user_win.vector = user_idx + 7'(VEC_BASE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vstat_q <= '0;
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= trap_found | user_found;
      if (trap_found) begin
        vstat_q <= trap_win;
      end else if (user_found) begin
        vstat_q <= user_win;
      end
    end
  end

  assign irq_req = irq_req_q;
  assign irq_sel = vstat_q;
endmodule : pic_controller

// [hdl/pic_pkg.sv]
// constants and types of the prioritized interrupt controller
// Summary of operation
// - thirty-three registers: controls, flags, enables, priorities, status
// - control A: nesting disable plus trap flags
// - control B: external pin edges, alternate table
// - hardware sets request flag, software write clears
// - source interrupts only while enable bit set
// - each user source gets one of eight levels
// - 3-bit priority, 7 highest, 0 disables
// - vector status latches vector and level
// - latched level equals presented interrupt priority
// - bits allocated in natural order of sources
// - status word bits 7:5 hold writable CPU level
// - read-only fourth level bit guards traps
// - priority fields reset 100, gaps read zero
// - enable word 2 resets zero, bit 13 zero
// - enable word 2 bit map per source
// - priority word 13 field map per source
// - traps at levels 10-14, masked by a CPU level at or above theirs
// - CPU level 7 blocks all user interrupts
package pic_pkg;
  localparam int N_FLAG_WORDS = 5;
  localparam int N_PRIO_WORDS = 18;
  localparam int N_FLAGS = 16 * N_FLAG_WORDS;
  localparam int N_SRC = 4 * N_PRIO_WORDS;
  localparam int N_EXT = 5;
  localparam int N_TRAP = 5;
  localparam int VEC_BASE = 8;
  // register word indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL_A = 6'h00;
  localparam logic [5:0] IDX_CTRL_B = 6'h01;
  localparam logic [5:0] IDX_FLAG0 = 6'h02;
  localparam logic [5:0] IDX_EN0 = 6'h07;
  localparam logic [5:0] IDX_PRIO0 = 6'h0c;
  localparam logic [5:0] IDX_VSTAT = 6'h1e;
  localparam logic [5:0] IDX_CPU_SR = 6'h1f;
  localparam logic [5:0] IDX_CORE = 6'h20;
  localparam int ADDR_W = 8;
  // field positions
  localparam int NEST_DIS_BIT = 15;
  localparam int ALT_TABLE_BIT = 15;
  localparam int CPU_LOW_LSB = 5;
  localparam int CPU_TOP_BIT = 3;
  localparam int VS_LEVEL_LSB = 8;
  // reset values and implemented-bit masks
  localparam logic [15:0] PRIO_RESET = 16'h4444;
  localparam logic [15:0] PRIO_MASK = 16'h7777;
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [15:0] EN2_MASK = 16'hdfff;
  localparam logic [15:0] FULL_MASK = 16'hffff;
  localparam logic [2:0] LEVEL_USER_MAX = 3'h7;
  localparam logic [3:0] TRAP_LEVEL_TOP = 4'he;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // natural-order slots of the external pins 0..4
  localparam int EXT_SRC [N_EXT] = '{0, 20, 29, 53, 54};
  typedef struct packed {
    logic [3:0] level;
    logic [6:0] vector;
  } pic_vec_t;
endpackage : pic_pkg

// [verif/pic_ctrl_asserts.sv]
// port assertions for the interrupt controller
`timescale 1ns/100ps
module pic_ctrl_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic irq_req,
  input wire pic_pkg::pic_vec_t irq_sel
);
  import pic_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  b_late_a: assert property (both_taken |-> ##[1:3] bvalid)
    else $error("write response late");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  r_late_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  ar_block_a: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");
  w_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  r_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  lvl_zero_a: assert property (irq_req |-> irq_sel.level != 4'h0)
    else $error("level zero presented");
  trap_lvl_a: assert property (
    irq_req && irq_sel.vector < 7'h08 |-> irq_sel.level > 4'h7)
    else $error("trap below level 8");
  user_lvl_a: assert property (
    irq_req && irq_sel.vector >= 7'h08 |-> irq_sel.level <= 4'h7)
    else $error("user source above level 7");
endmodule : pic_ctrl_asserts

bind pic_controller pic_ctrl_asserts u_chk (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
  .arready, .rvalid, .rready, .rdata, .irq_req, .irq_sel);

// [verif/pic_src_model.sv]
// far-side sources: peripherals, pins, traps and cpu level bit
`timescale 1ns/100ps
module pic_src_model (
  input wire logic aclk,
  output logic [pic_pkg::N_FLAGS-1:0] periph_req,
  output logic [pic_pkg::N_EXT-1:0] ext_irq_pin,
  output logic [pic_pkg::N_TRAP-1:0] trap_req,
  output logic cpu_priority_top
);
  import pic_pkg::*;
  initial begin
    periph_req = '0;
    ext_irq_pin = '0;
    trap_req = '0;
    cpu_priority_top = 1'b0;
  end
  task pulse(input int i);
    periph_req[i] <= 1'b1;
    @(posedge aclk);
    periph_req[i] <= 1'b0;
  endtask : pulse
  task trap(input int k);
    trap_req[k] <= 1'b1;
    @(posedge aclk);
    trap_req[k] <= 1'b0;
  endtask : trap
  // pins are asynchronous, so hold long enough to pass the synchroniser
  task pin(input int k);
    ext_irq_pin[k] <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_irq_pin[k] <= 1'b0;
  endtask : pin
  task set_top(input logic b);
    cpu_priority_top <= b;
  endtask : set_top
endmodule : pic_src_model

// [verif/tb_top.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
module tb_top;
  import pic_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq_req, alt_table_sel;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pic_vec_t irq_sel;
  logic [N_FLAGS-1:0] periph_req;
  logic [N_EXT-1:0] ext_irq_pin;
  logic [N_TRAP-1:0] trap_req;
  logic cpu_priority_top;
  int errors = 0, checked = 0;
  logic [3:0] strb = 4'hf;
  always #5 aclk = ~aclk;
  pic_controller DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .periph_req,
    .ext_irq_pin, .trap_req, .cpu_priority_top, .irq_req, .irq_sel,
    .alt_table_sel);
  pic_src_model SRC (.aclk, .periph_req, .ext_irq_pin, .trap_req,
    .cpu_priority_top);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta, tw, pa, pw;
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = awready && pa;
      tw = wready && pw;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    // late bready lets the response-hold check see a stall
    repeat (2) @(posedge aclk);
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = bvalid;
      tw = (bresp === er);
      @(posedge aclk);
    end while (!ta);
    bready <= 1'b0;
    chk("bresp", 32'h1, {31'h0, tw});
    @(posedge aclk);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!t);
    rready <= 1'b0;
    chk("rdata", {16'h0000, e}, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
    @(posedge aclk);
  endtask : rdc
  task irq(input logic [3:0] l, input logic [6:0] v);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("irq", {20'h0, 1'b1, l, v}, {20'h0, irq_req, irq_sel});
    @(posedge aclk);
  endtask : irq
  task noirq;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("irq_req", 32'h0, {31'h0, irq_req});
    @(posedge aclk);
  endtask : noirq
  task t_regs;
    rdc(8'h48, 16'h4444, 2'h0);
    rdc(8'h64, 16'h4444, 2'h0);
    rdc(8'h24, 16'h0000, 2'h0);
    wr(8'h24, 16'hffff, 2'h0);
    rdc(8'h24, 16'hdfff, 2'h0);
    wr(8'h48, 16'hffff, 2'h0);
    rdc(8'h48, 16'h7777, 2'h0);
    wr(8'h24, 16'h0000, 2'h0);
    wr(8'h84, 16'h1234, 2'h2);
    rdc(8'h84, 16'h0000, 2'h2);
    wr(8'h78, 16'hffff, 2'h0);
    rdc(8'h78, 16'h0000, 2'h0);
    wr(8'h04, 16'h8000, 2'h0);
    chk("alt", 32'h1, {31'h0, alt_table_sel});
    wr(8'h04, 16'h0000, 2'h0);
    SRC.set_top(1'b1);
    wr(8'h80, 16'h0000, 2'h0);
    rdc(8'h80, 16'h0008, 2'h0);
    SRC.set_top(1'b0);
    wr(8'h7c, 16'h00a0, 2'h0);
    rdc(8'h7c, 16'h00a0, 2'h0);
    wr(8'h7c, 16'h0000, 2'h0);
    // low byte strobe off: the cpu level must not move
    strb = 4'h2;
    wr(8'h7c, 16'h00e0, 2'h0);
    strb = 4'hf;
    rdc(8'h7c, 16'h0000, 2'h0);
  endtask : t_regs
  task t_present;
    SRC.pulse(5);
    rdc(8'h08, 16'h0020, 2'h0);
    noirq();
    wr(8'h1c, 16'h0030, 2'h0);
    irq(4'h4, 7'h0d);
    wr(8'h34, 16'h4477, 2'h0);
    SRC.pulse(4);
    irq(4'h7, 7'h0c);
    wr(8'h34, 16'h4475, 2'h0);
    irq(4'h7, 7'h0d);
  endtask : t_present
  task t_mask;
    wr(8'h7c, 16'h00c0, 2'h0);
    irq(4'h7, 7'h0d);
    wr(8'h7c, 16'h00e0, 2'h0);
    noirq();
    SRC.trap(0);
    irq(4'he, 7'h01);
    wr(8'h00, 16'h0000, 2'h0);
    wr(8'h7c, 16'h0000, 2'h0);
    irq(4'h7, 7'h0d);
    wr(8'h7c, 16'h0020, 2'h0);
    wr(8'h00, 16'h8000, 2'h0);
    noirq();
    rdc(8'h00, 16'h8000, 2'h0);
    wr(8'h00, 16'h0000, 2'h0);
    wr(8'h7c, 16'h0000, 2'h0);
    wr(8'h34, 16'h4400, 2'h0);
    noirq();
    wr(8'h08, 16'h0000, 2'h0);
    rdc(8'h08, 16'h0000, 2'h0);
  endtask : t_mask
  task t_ext;
    SRC.pin(0);
    repeat (4) @(posedge aclk);
    rdc(8'h08, 16'h0001, 2'h0);
  endtask : t_ext
  task report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_present();
    t_mask();
    t_ext();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    report_and_stop();
  end
endmodule : tb_top
